// *** rtl/rcrb_regbank.sv ***
`timescale 1ns/1ps
// Summary of operation
// - First bit zero reads status, one writes
// - Bits 15..13 prefix selects main setup word
// - Each register has prefix and power-on word
// - Bit 15 set when fill count reached
// - Bit 14 overrun, cleared after status read
// - Bit 13 timer overflow, cleared after read
// - Bit 12 high while supply below threshold and setup bit 10 enables the monitor
// - Bit 11 high while buffer empty
// - Bit 10 high while strength above threshold
// - Bit 9 high while data quality good
// - Bit 8 high while bit clock locked
// - Bit 7 toggles per adjust cycle
// - Bit 6 set on two equal offsets
// - Bit 5 gives offset sign
// - Bits 4..0 give offset magnitude
// - Setup bits 12..11 select band
// - Setup bit 10 enables supply monitor
// - Setup bit 9 enables sleep timer
// - Setup bit 8 enables reference oscillator
// - Setup bits 7..4 select load capacitance
// - Setup bit 0 disables host clock output
// - Setup bits 3..1 select baseband width
module rcrb_regbank #(
   parameter int SYNC_STAGES = 2
) (
   // Clock and reset
   input  wire logic                  i_ref_clk,
   input  wire logic                  i_reset_n,
   // Serial port pins
   input  wire logic                  i_sel_n,
   input  wire logic                  i_sck,
   input  wire logic                  i_sdi,
   output logic                       o_sdo,
   // Radio core reports (same clock)
   input  wire rcrb_pkg::rcrb_core_t  i_core,
   // Decoded setup fields
   output rcrb_pkg::rcrb_setup_t      o_setup,
   output logic                       o_bb_reserved,
   output logic                       o_trim_adjust_enable,
   output logic [3:0]                 o_fill_limit,
   output logic [4:0]                 o_supply_threshold,
   // Whole stored words of the other registers except trim
   output logic [15:0]                o_carrier_channel_word,
   output logic [15:0]                o_rx_path_control,
   output logic [15:0]                o_demod_setup,
   output logic [15:0]                o_rx_buffer_setup,
   output logic [15:0]                o_bit_rate_setup,
   output logic [15:0]                o_sleep_period_setup,
   output logic [15:0]                o_listen_duty_setup,
   output logic [15:0]                o_supply_monitor_setup
);
   // Only the two-flop synchroniser is built; other depths are refused
   if (SYNC_STAGES != 2) begin : g_bad_stages
      $error("rcrb_regbank: SYNC_STAGES must be 2");
   end

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   logic [1:0] sel_s_r;                 // Select, stage 0 read only by stage 1
   logic [1:0] sck_s_r;                 // Serial clock
   logic [1:0] sdi_s_r;                 // Serial data
   logic       sck_d_r;                 // Previous synced clock for edges

   // Two flops per pin; the link clock is sampled, not used as a clock
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sel_s_r <= 2'h3;
         sck_s_r <= 2'h0;
         sdi_s_r <= 2'h0;
         sck_d_r <= 1'b0;
      end else begin
         sel_s_r <= {sel_s_r[0], i_sel_n};
         sck_s_r <= {sck_s_r[0], i_sck};
         sdi_s_r <= {sdi_s_r[0], i_sdi};
         sck_d_r <= sck_s_r[1];
      end
   end

   logic sel_act;                       // Frame is open
   logic sck_rise;                      // Sample edge
   logic sck_fall;                      // Shift edge
   assign sel_act  = ~sel_s_r[1];
   assign sck_rise = sel_act & sck_s_r[1] & ~sck_d_r;
   assign sck_fall = sel_act & ~sck_s_r[1] & sck_d_r;

   // ==========================================================
   // Word receiver
   // ==========================================================
   logic [15:0] shift_r;                // Bits received so far
   logic [4:0]  cnt_r;                  // Bits received in this frame
   logic        is_read_r;              // Frame is a status read
   logic        sel_d_r;                // Previous frame state
   logic        word_done;              // Full word ended with select high
   logic        read_done;              // Status read completed

   // Bit counter and shifter; a frame shorter than 16 bits is dropped
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         shift_r   <= 16'h0000;
         cnt_r     <= 5'h00;
         is_read_r <= 1'b0;
         sel_d_r   <= 1'b0;
      end else begin
         sel_d_r <= sel_act;
         if (!sel_act) begin
            cnt_r <= 5'h00;
         end else if (sck_rise && cnt_r != rcrb_pkg::CNT_FULL) begin
            shift_r <= {shift_r[14:0], sdi_s_r[1]};
            cnt_r   <= cnt_r + 5'h01;
            if (cnt_r == 5'h00) begin
               is_read_r <= ~sdi_s_r[1];
            end
         end
      end
   end

   // Words act only when select rises after sixteen or more bits; bits past the 16th are ignored
   assign word_done = sel_d_r & ~sel_act & (cnt_r == rcrb_pkg::CNT_FULL);
   assign read_done = word_done & is_read_r;

   // ==========================================================
   // Prefix decode
   // ==========================================================
   rcrb_pkg::rcrb_reg_sel_t wsel;

   // Longer prefixes tried first so the three-bit ones cannot shadow them
   always_comb begin
      wsel = rcrb_pkg::RCRB_R_NONE;
      if ((shift_r & rcrb_pkg::PFX_BYTE_MASK) == rcrb_pkg::PFX_TRIM) begin
         wsel = rcrb_pkg::RCRB_R_TRIM;
      end else if ((shift_r & rcrb_pkg::PFX_BYTE_MASK) == rcrb_pkg::PFX_PATH) begin
         wsel = rcrb_pkg::RCRB_R_PATH;
      end else if ((shift_r & rcrb_pkg::PFX_BYTE_MASK) == rcrb_pkg::PFX_DEMOD) begin
         wsel = rcrb_pkg::RCRB_R_DEMOD;
      end else if ((shift_r & rcrb_pkg::PFX_BYTE_MASK) == rcrb_pkg::PFX_BUFSET) begin
         wsel = rcrb_pkg::RCRB_R_BUFSET;
      end else if ((shift_r & rcrb_pkg::PFX_BYTE_MASK) == rcrb_pkg::PFX_RATE) begin
         wsel = rcrb_pkg::RCRB_R_RATE;
      end else if ((shift_r & rcrb_pkg::PFX_BYTE_MASK) == rcrb_pkg::PFX_DUTY) begin
         wsel = rcrb_pkg::RCRB_R_DUTY;
      end else if ((shift_r & rcrb_pkg::PFX_BYTE_MASK) == rcrb_pkg::PFX_SUPPLY) begin
         wsel = rcrb_pkg::RCRB_R_SUPPLY;
      end else if ((shift_r & rcrb_pkg::PFX_CHAN_MASK) == rcrb_pkg::PFX_CHAN) begin
         wsel = rcrb_pkg::RCRB_R_CHAN;
      end else if ((shift_r & rcrb_pkg::PFX_SETUP_MASK) == rcrb_pkg::PFX_SETUP) begin
         wsel = rcrb_pkg::RCRB_R_SETUP;
      end else if ((shift_r & rcrb_pkg::PFX_SLEEP_MASK) == rcrb_pkg::PFX_SLEEP) begin
         wsel = rcrb_pkg::RCRB_R_SLEEP;
      end
   end

   // ==========================================================
   // Write registers
   // ==========================================================
   logic [15:0] setup_r;
   logic [15:0] trim_r;
   logic [15:0] chan_r;
   logic [15:0] path_r;
   logic [15:0] demod_r;
   logic [15:0] bufset_r;
   logic [15:0] rate_r;
   logic [15:0] sleep_r;
   logic [15:0] duty_r;
   logic [15:0] supply_r;

   // Whole word is stored; prefix bits are constant so this is harmless
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         setup_r  <= rcrb_pkg::POR_SETUP;
         trim_r   <= rcrb_pkg::POR_TRIM;
         chan_r   <= rcrb_pkg::POR_CHAN;
         path_r   <= rcrb_pkg::POR_PATH;
         demod_r  <= rcrb_pkg::POR_DEMOD;
         bufset_r <= rcrb_pkg::POR_BUFSET;
         rate_r   <= rcrb_pkg::POR_RATE;
         sleep_r  <= rcrb_pkg::POR_SLEEP;
         duty_r   <= rcrb_pkg::POR_DUTY;
         supply_r <= rcrb_pkg::POR_SUPPLY;
      end else if (word_done && !is_read_r) begin
         unique case (wsel)
            rcrb_pkg::RCRB_R_SETUP:  setup_r  <= shift_r;
            rcrb_pkg::RCRB_R_TRIM:   trim_r   <= shift_r;
            rcrb_pkg::RCRB_R_CHAN:   chan_r   <= shift_r;
            rcrb_pkg::RCRB_R_PATH:   path_r   <= shift_r;
            rcrb_pkg::RCRB_R_DEMOD:  demod_r  <= shift_r;
            rcrb_pkg::RCRB_R_BUFSET: bufset_r <= shift_r;
            rcrb_pkg::RCRB_R_RATE:   rate_r   <= shift_r;
            rcrb_pkg::RCRB_R_SLEEP:  sleep_r  <= shift_r;
            rcrb_pkg::RCRB_R_DUTY:   duty_r   <= shift_r;
            rcrb_pkg::RCRB_R_SUPPLY: supply_r <= shift_r;
            rcrb_pkg::RCRB_R_NONE:   ;
         endcase
      end
   end

   // ==========================================================
   // Status flags
   // ==========================================================
   logic       fill_r;                  // Fill count reached, follows core
   logic       ovr_r;                   // Overrun, cleared after read
   logic       wake_r;                  // Timer overflow, cleared after read
   logic       tgl_r;                   // Adjust cycle toggle
   logic       stable_r;                // Two equal offsets seen
   logic [5:0] last_off_r;              // Previous offset measurement

   // Sticky overrun and wake flags: a new event in the clearing cycle wins over the clear
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         fill_r <= 1'b0;
         ovr_r  <= 1'b0;
         wake_r <= 1'b0;
      end else begin
         // Fill flag drops once the buffer drains, as the core reports
         fill_r <= i_core.fill_bit;
         if (i_core.overrun) begin
            ovr_r <= 1'b1;
         end else if (read_done) begin
            ovr_r <= 1'b0;
         end
         // Overflows only count while the sleep timer is enabled
         if (i_core.sleep_ovf && setup_r[rcrb_pkg::SET_WAKE]) begin
            wake_r <= 1'b1;
         end else if (read_done) begin
            wake_r <= 1'b0;
         end
      end
   end

   // Frequency adjuster tracking
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         tgl_r      <= 1'b0;
         stable_r   <= 1'b0;
         last_off_r <= 6'h00;
      end else if (i_core.adjust_done) begin
         tgl_r      <= ~tgl_r;
         stable_r   <= (i_core.offset == last_off_r);
         last_off_r <= i_core.offset;
      end
   end

   rcrb_pkg::rcrb_status_t stat;

   // Live status; monitor bit reads low while the monitor is off
   always_comb begin
      stat.buffer_fill_reached       = fill_r;
      stat.buffer_overrun_flag       = ovr_r;
      stat.sleep_timer_overflow_flag = wake_r;
      stat.supply_low_flag           = i_core.supply_low
                                       & setup_r[rcrb_pkg::SET_LBD];
      stat.buffer_empty_flag         = i_core.empty;
      stat.strength_above_flag       = i_core.strength_above;
      stat.good_quality_flag         = i_core.good_quality;
      stat.bit_clock_locked_flag     = i_core.locked;
      stat.adjust_cycle_toggle       = tgl_r;
      stat.freq_stable_flag          = stable_r;
      stat.offset_sign               = i_core.offset[5];
      stat.offset_mag                = i_core.offset[4:0];
   end

   // ==========================================================
   // Status shifter
   // ==========================================================
   logic [15:0] tx_r;                   // Snapshot being sent

   // Snapshot at select fall so the word is coherent; MSB out first.
   // The offset is frozen in the snapshot too; later adjuster cycles show on the next read.
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         tx_r  <= 16'h0000;
         o_sdo <= 1'b0;
      end else if (sel_act && !sel_d_r) begin
         tx_r  <= stat;
         o_sdo <= 1'b0;
      // The fall after the 16th rise must still shift, or bit 0 never leaves
      end else if (sck_fall && is_read_r) begin
         o_sdo <= tx_r[15];
         tx_r  <= {tx_r[14:0], 1'b0};
      end else if (!sel_act) begin
         o_sdo <= 1'b0;
      end
   end

   // ==========================================================
   // Decoded outputs
   // ==========================================================
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_setup                <= '0;
         o_bb_reserved          <= 1'b0;
         o_trim_adjust_enable   <= 1'b0;
         o_fill_limit           <= 4'h0;
         o_supply_threshold     <= 5'h00;
         o_carrier_channel_word <= 16'h0000;
         o_rx_path_control      <= 16'h0000;
         o_demod_setup          <= 16'h0000;
         o_rx_buffer_setup      <= 16'h0000;
         o_bit_rate_setup       <= 16'h0000;
         o_sleep_period_setup   <= 16'h0000;
         o_listen_duty_setup    <= 16'h0000;
         o_supply_monitor_setup <= 16'h0000;
      end else begin
         o_setup.band_select <= setup_r[rcrb_pkg::SET_BAND_HI:rcrb_pkg::SET_BAND_LO];
         o_setup.supply_monitor_enable <= setup_r[rcrb_pkg::SET_LBD];
         o_setup.sleep_timer_enable    <= setup_r[rcrb_pkg::SET_WAKE];
         o_setup.reference_osc_enable  <= setup_r[rcrb_pkg::SET_OSC];
         o_setup.load_cap_code <= setup_r[rcrb_pkg::SET_CAP_HI:rcrb_pkg::SET_CAP_LO];
         o_setup.baseband_width_code <= setup_r[rcrb_pkg::SET_BB_HI:rcrb_pkg::SET_BB_LO];
         o_setup.host_clock_output_disable <= setup_r[rcrb_pkg::SET_CLKDIS];
         o_bb_reserved <=
            (setup_r[rcrb_pkg::SET_BB_HI:rcrb_pkg::SET_BB_LO] == rcrb_pkg::BB_RSVD_LO) |
            (setup_r[rcrb_pkg::SET_BB_HI:rcrb_pkg::SET_BB_LO] == rcrb_pkg::BB_RSVD_HI);
         o_trim_adjust_enable   <= trim_r[rcrb_pkg::TRIM_EN];
         o_fill_limit <= bufset_r[rcrb_pkg::BUF_FILL_HI:rcrb_pkg::BUF_FILL_LO];
         o_supply_threshold     <= supply_r[rcrb_pkg::SUP_THR_HI:0];
         o_carrier_channel_word <= chan_r;
         o_rx_path_control      <= path_r;
         o_demod_setup          <= demod_r;
         o_rx_buffer_setup      <= bufset_r;
         o_bit_rate_setup       <= rate_r;
         o_sleep_period_setup   <= sleep_r;
         o_listen_duty_setup    <= duty_r;
         o_supply_monitor_setup <= supply_r;
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   property p_overrun_set;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      i_core.overrun |=> ovr_r;
   endproperty
   a_overrun_set: assert property (p_overrun_set) else $error("overrun lost");

   property p_overrun_clear;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (read_done && !i_core.overrun) |=> !ovr_r;
   endproperty
   a_overrun_clear: assert property (p_overrun_clear) else $error("overrun kept");

   property p_wake_clear;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (read_done && !i_core.sleep_ovf) |=> !wake_r;
   endproperty
   a_wake_clear: assert property (p_wake_clear) else $error("wake flag kept");

   property p_toggle;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      i_core.adjust_done |=> (tgl_r != $past(tgl_r));
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle missed");

   property p_short_frame;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (sel_d_r && !sel_act && cnt_r != rcrb_pkg::CNT_FULL) |=> $stable(setup_r);
   endproperty
   a_short_frame: assert property (p_short_frame) else $error("short word stored");

   property p_setup_write;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (word_done && !is_read_r && wsel == rcrb_pkg::RCRB_R_SETUP)
         |=> (setup_r == $past(shift_r)) ##2 (o_setup.host_clock_output_disable == setup_r[0]);
   endproperty
   a_setup_write: assert property (p_setup_write) else $error("setup not stored");

   property p_band_out;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      $changed(setup_r) |=> (o_setup.band_select == $past(setup_r[12:11]));
   endproperty
   a_band_out: assert property (p_band_out) else $error("band field wrong");

   property p_stable;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (i_core.adjust_done && i_core.offset == last_off_r) |=> stable_r;
   endproperty
   a_stable: assert property (p_stable) else $error("stable flag missed");

   property p_read_no_write;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      read_done |=> $stable(trim_r) && $stable(chan_r);
   endproperty
   a_read_no_write: assert property (p_read_no_write) else $error("read wrote");
endmodule

// *** rtl/rcrb_pkg.sv ***
package rcrb_pkg;
   // ==========================================================
   // Word layout
   // ==========================================================
   localparam int WORD_W = 16;
   localparam int CNT_W  = 5;
   localparam logic [4:0] CNT_FULL = 5'h10;

   // Register selector, one code per write register
   typedef enum logic [3:0] {
      RCRB_R_SETUP   = 4'h0,
      RCRB_R_TRIM    = 4'h1,
      RCRB_R_CHAN    = 4'h2,
      RCRB_R_PATH    = 4'h3,
      RCRB_R_DEMOD   = 4'h4,
      RCRB_R_BUFSET  = 4'h5,
      RCRB_R_RATE    = 4'h6,
      RCRB_R_SLEEP   = 4'h7,
      RCRB_R_DUTY    = 4'h8,
      RCRB_R_SUPPLY  = 4'h9,
      RCRB_R_NONE    = 4'hF
   } rcrb_reg_sel_t;

   // ==========================================================
   // Command prefixes (value and mask of the upper bits)
   // ==========================================================
   localparam logic [15:0] PFX_SETUP_MASK  = 16'hE000;
   localparam logic [15:0] PFX_SETUP       = 16'h8000;
   localparam logic [15:0] PFX_CHAN_MASK   = 16'hF000;
   localparam logic [15:0] PFX_CHAN        = 16'hA000;
   localparam logic [15:0] PFX_SLEEP_MASK  = 16'hE000;
   localparam logic [15:0] PFX_SLEEP       = 16'hE000;
   localparam logic [15:0] PFX_BYTE_MASK   = 16'hFF00;
   localparam logic [15:0] PFX_TRIM        = 16'hC600;
   localparam logic [15:0] PFX_PATH        = 16'hC000;
   localparam logic [15:0] PFX_DEMOD       = 16'hC400;
   localparam logic [15:0] PFX_BUFSET      = 16'hCE00;
   localparam logic [15:0] PFX_RATE        = 16'hC800;
   localparam logic [15:0] PFX_DUTY        = 16'hCC00;
   localparam logic [15:0] PFX_SUPPLY      = 16'hC200;

   // ==========================================================
   // Power-on words
   // ==========================================================
   localparam logic [15:0] POR_SETUP  = 16'h893A;
   localparam logic [15:0] POR_TRIM   = 16'hC6F7;
   localparam logic [15:0] POR_CHAN   = 16'hA680;
   localparam logic [15:0] POR_PATH   = 16'hC0C1;
   localparam logic [15:0] POR_DEMOD  = 16'hC42C;
   localparam logic [15:0] POR_BUFSET = 16'hCE89;
   localparam logic [15:0] POR_RATE   = 16'hC823;
   localparam logic [15:0] POR_SLEEP  = 16'hE196;
   localparam logic [15:0] POR_DUTY   = 16'hCC0E;
   localparam logic [15:0] POR_SUPPLY = 16'hC200;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int SET_BAND_HI = 12;
   localparam int SET_BAND_LO = 11;
   localparam int SET_LBD     = 10;
   localparam int SET_WAKE    = 9;
   localparam int SET_OSC     = 8;
   localparam int SET_CAP_HI  = 7;
   localparam int SET_CAP_LO  = 4;
   localparam int SET_BB_HI   = 3;
   localparam int SET_BB_LO   = 1;
   localparam int SET_CLKDIS  = 0;
   localparam int TRIM_EN     = 0;
   localparam int BUF_FILL_HI = 7;
   localparam int BUF_FILL_LO = 4;
   localparam int SUP_THR_HI  = 4;

   // Baseband codes that are reserved
   localparam logic [2:0] BB_RSVD_LO = 3'h0;
   localparam logic [2:0] BB_RSVD_HI = 3'h7;

   // Status word as sent, most significant field first
   typedef struct packed {
      logic       buffer_fill_reached;
      logic       buffer_overrun_flag;
      logic       sleep_timer_overflow_flag;
      logic       supply_low_flag;
      logic       buffer_empty_flag;
      logic       strength_above_flag;
      logic       good_quality_flag;
      logic       bit_clock_locked_flag;
      logic       adjust_cycle_toggle;
      logic       freq_stable_flag;
      logic       offset_sign;
      logic [4:0] offset_mag;
   } rcrb_status_t;

   // Decoded main setup fields
   typedef struct packed {
      logic [1:0] band_select;
      logic       supply_monitor_enable;
      logic       sleep_timer_enable;
      logic       reference_osc_enable;
      logic [3:0] load_cap_code;
      logic [2:0] baseband_width_code;
      logic       host_clock_output_disable;
   } rcrb_setup_t;

   // Events and levels reported by the radio core
   typedef struct packed {
      logic       fill_bit;
      logic       overrun;
      logic       sleep_ovf;
      logic       supply_low;
      logic       empty;
      logic       strength_above;
      logic       good_quality;
      logic       locked;
      logic       adjust_done;
      logic [5:0] offset;
   } rcrb_core_t;
endpackage

// *** verif/rcrb_host.sv ***
`timescale 1ns/1ps
// ==========================================================
// Host master: sck rests low between frames, sdi flips when idle
module rcrb_host (
   // Clock and status line
   input  wire logic i_ref_clk,
   input  wire logic i_sdo,
   // Serial pins driven by the host
   output logic      o_sel_n,
   output logic      o_sck,
   output logic      o_sdi
);
   initial begin
      o_sel_n = 1'b1;
      o_sck   = 1'b0;
      o_sdi   = 1'b0;
   end
   // Frame of n bits, MSB first; 8 ref clocks per sck period
   task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rd);
      rd = 16'h0;
      @(negedge i_ref_clk) o_sel_n = 1'b0;
      repeat (4) @(negedge i_ref_clk);
      for (int i = 0; i < n; i++) begin
         o_sdi = w[15-i];
         repeat (2) @(negedge i_ref_clk);
         o_sck = 1'b1;
         repeat (4) @(negedge i_ref_clk);
         // Late sample: sdo holds until the next fall
         if (i > 0) rd = {rd[14:0], i_sdo};
         o_sck = 1'b0;
         repeat (2) @(negedge i_ref_clk);
      end
      repeat (6) @(negedge i_ref_clk);
      rd = {rd[14:0], i_sdo};
      o_sel_n = 1'b1;
      o_sdi   = ~o_sdi;
      repeat (6) @(negedge i_ref_clk);
   endtask
endmodule

// *** verif/test_receiver_command_register_bank.sv ***
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the command register bank
module test_receiver_command_register_bank;
   logic              i_ref_clk, i_reset_n, i_sel_n, i_sck, i_sdi, o_sdo, bbr, trim;
   rcrb_pkg::rcrb_core_t  i_core;  // Radio core reports
   rcrb_pkg::rcrb_setup_t su;      // Decoded setup fields
   logic [15:0]       chan, path, slp, rd, dem, bfs, rate, duty, sup;
   logic [3:0]        fl;      // Buffer fill limit field
   logic [4:0]        thr;     // Supply threshold field
   int                errors, cmp_count, cyc;
   rcrb_regbank DUT (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_sel_n(i_sel_n),
      .i_sck(i_sck), .i_sdi(i_sdi), .o_sdo(o_sdo), .i_core(i_core), .o_setup(su),
      .o_bb_reserved(bbr), .o_trim_adjust_enable(trim), .o_fill_limit(fl),
      .o_supply_threshold(thr), .o_carrier_channel_word(chan), .o_rx_path_control(path),
      .o_demod_setup(dem), .o_rx_buffer_setup(bfs), .o_bit_rate_setup(rate),
      .o_sleep_period_setup(slp), .o_listen_duty_setup(duty), .o_supply_monitor_setup(sup));
   rcrb_host host (.i_ref_clk(i_ref_clk), .i_sdo(o_sdo), .o_sel_n(i_sel_n), .o_sck(i_sck),
      .o_sdi(i_sdi));
   // Clock of 50 ns period
   always #25 i_ref_clk = ~i_ref_clk;
   // Hang guard: a frame takes about 150 clocks
   always @(posedge i_ref_clk) begin
      cyc++;
      if (cyc == 8000) begin
         errors++;
         test_done();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Power-on words, clock output running
   task automatic t_por;
      chk({3'h0, su}, rcrb_pkg::POR_SETUP & 16'h1FFF);
      chk(chan, 16'hA680);
      chk(slp, 16'hE196);
      chk({15'h0, trim}, 16'h1);
      chk(path, 16'hC0C1);
      chk(dem, 16'hC42C);
      chk(bfs, 16'hCE89);
      chk(rate, 16'hC823);
      chk(duty, 16'hCC0E);
      chk(sup, 16'hC200);
      chk({12'h0, fl}, 16'h0008);
   endtask
   // Setup fields, then a short frame that must be dropped
   task automatic t_setup;
      host.xfer(16'h9EF0, 16, rd);
      chk({3'h0, su}, 16'h1EF0);
      chk({15'h0, bbr}, 16'h1);
      host.xfer(16'h86F3, 12, rd);
      chk({3'h0, su}, 16'h1EF0);
      host.xfer(16'h86F3, 16, rd);
      chk({3'h0, su}, 16'h06F3);
   endtask
   // Other registers by their own prefix
   task automatic t_words;
      host.xfer(16'hA123, 16, rd);
      host.xfer(16'hE00F, 16, rd);
      host.xfer(16'hC6F6, 16, rd);
      host.xfer(16'hC0C0, 16, rd);
      host.xfer(16'hC21F, 16, rd);
      chk(sup, 16'hC21F);
      chk({11'h0, thr}, 16'h001F);
      chk(chan, 16'hA123);
      chk(slp, 16'hE00F);
      chk(path, 16'hC0C0);
      chk({15'h0, trim}, 16'h0);
   endtask
   // Status read, then sticky flags gone on the second read
   task automatic t_status;
      i_core = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 6'h25};
      @(negedge i_ref_clk);
      i_core.overrun = 1'b0;
      i_core.sleep_ovf = 1'b0;
      i_core.adjust_done = 1'b0;
      @(negedge i_ref_clk) i_core.adjust_done = 1'b1;
      @(negedge i_ref_clk) i_core.adjust_done = 1'b0;
      host.xfer(16'h0000, 16, rd);
      chk(rd, 16'hF565);
      host.xfer(16'h0000, 16, rd);
      chk(rd, 16'h9565);
   endtask
   initial begin
      i_ref_clk = 1'b0;
      i_reset_n = 1'b0;
      i_core = '0;
      repeat (12) @(negedge i_ref_clk);
      i_reset_n = 1'b1;
      repeat (2) @(negedge i_ref_clk);
      t_por();
      t_setup();
      t_words();
      t_status();
      test_done();
   end
endmodule
